//--- hdl/cfr_params.svh
`ifndef CFR_PARAMS_SVH
`define CFR_PARAMS_SVH

// Register indices; byte address is four times the index
`define CFR_IDX_CLOCK_RATE_SELECT   6'h02
`define CFR_IDX_STAGE_ENABLES       6'h03
`define CFR_IDX_IRQ_PENDING_FLAGS   6'h04
`define CFR_IDX_IRQ_ENABLE_MASK     6'h05
`define CFR_IDX_IRQ_CLEAR           6'h10

// Reset values
`define CFR_RST_CLOCK_RATE_SELECT   16'h1310
`define CFR_RST_STAGE_ENABLES       16'h0000
`define CFR_RST_IRQ_ENABLE_MASK     8'h00

// Clock configuration fields
`define CFR_CLK_EDGE_BIT            2
`define CFR_CLK_BYPASS_BIT          3
`define CFR_CLK_IN_RATE_LSB         4
`define CFR_CLK_CORE_RATE_LSB       8
`define CFR_CLK_OUT_RATE_LSB        12
`define CFR_CLK_OUT_SRC_LSB         14
`define CFR_CLK_WRITABLE            16'hf33c

// Datapath enable fields
`define CFR_EN_NODELAY_LSB          0
`define CFR_EN_INTERP_BIT           4
`define CFR_EN_LIMITER_BIT          5
`define CFR_EN_DELAY_LSB            8
`define CFR_EN_WRITABLE             16'h0f3f

// Flag register: eight sources, bits 15:8 reserved
`define CFR_NUM_FLAGS               8

`endif

//--- hdl/cfr_pkg.sv
package cfr_pkg;

    // Rate code of one derived clock
    typedef enum logic [1:0] {
        CFR_RATE_OFF = 2'h0,
        CFR_RATE_X1  = 2'h1,
        CFR_RATE_X2  = 2'h2,
        CFR_RATE_X4  = 2'h3
    } cfr_rate_t;

    // Write channel sequencer
    typedef enum logic [0:0] {
        CFR_WR_IDLE = 1'h0,
        CFR_WR_RESP = 1'h1
    } cfr_wr_state_t;

    // Read channel sequencer
    typedef enum logic [0:0] {
        CFR_RD_IDLE = 1'h0,
        CFR_RD_DATA = 1'h1
    } cfr_rd_state_t;

    typedef logic [7:0] cfr_flags_t;

endpackage

//--- hdl/cfr_irq_if.sv
`timescale 1ns/1ps
`default_nettype none

interface cfr_irq_if;
    logic [7:0] event_pulse;
    logic [7:0] clear_pulse;
    logic [7:0] mask;
    logic [7:0] flags;
    logic       irq;

    modport ctrl (
        output event_pulse,
        output clear_pulse,
        output mask,
        input  flags,
        input  irq
    );
    modport unit (
        input  event_pulse,
        input  clear_pulse,
        input  mask,
        output flags,
        output irq
    );
endinterface

`default_nettype wire

//--- hdl/cfr_irq_flags.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfr_params.svh"

module cfr_irq_flags
    import cfr_pkg::*;
(
    // Clock and reset
    input  wire logic clk,
    input  wire logic resetn,
    input  wire logic ce,
    // Flag traffic
    cfr_irq_if.unit   port_if
);

    cfr_flags_t flags_reg;
    cfr_flags_t flags_next;
    logic       irq_reg;
    logic       irq_next;

    // One sticky bit per source; a new event beats a clear in the same cycle
    genvar i;
    generate
        for (i = 0; i < `CFR_NUM_FLAGS; i++) begin : g_flag
            assign flags_next[i] = port_if.event_pulse[i] |
                                   (flags_reg[i] &
                                    ~port_if.clear_pulse[i]);
        end
    endgenerate

    // Mask gates only the pin, never the sticky bit itself
    assign irq_next = |(flags_next & port_if.mask);

    // State, frozen while the clock enable is low
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            flags_reg <= 8'h00;
            irq_reg   <= 1'b0;
        end else if (ce) begin
            flags_reg <= flags_next;
            irq_reg   <= irq_next;
        end
    end

    assign port_if.flags = flags_reg;
    assign port_if.irq   = irq_reg;

endmodule

`default_nettype wire

//--- hdl/cfr_global_ctrl.sv
`timescale 1ns/1ps
`default_nettype none
`include "cfr_params.svh"

module cfr_global_ctrl
    import cfr_pkg::*;
(
    // Clock, reset and freeze
    input  wire logic        clk,
    input  wire logic        resetn,
    input  wire logic        ce,
    // AXI4-Lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic [2:0]  s_axi_awprot,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // AXI4-Lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // AXI4-Lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // AXI4-Lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic [2:0]  s_axi_arprot,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // AXI4-Lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // Event pulses from snapshot, timer, power, update and checksum units
    input  wire logic [7:0]  event_pulse,
    // Interrupt to the host
    output logic             irq,
    // Clock generation controls
    output logic             ref_edge_falling,
    output logic             pll_bypass,
    output cfr_rate_t        in_clk_rate,
    output cfr_rate_t        core_clk_rate,
    output cfr_rate_t        out_clk_rate,
    output logic [2:0]       clk_running,
    output logic [1:0]       out_clk_src_sel,
    // Datapath controls
    output logic [3:0]       peak_cancel_stage_en,
    output logic [3:0]       peak_cancel_stage_skip_delay,
    output logic             interp_en,
    output logic             limiter_en,
    output logic             datapath_bypass
);

    localparam logic [1:0] RESP_OKAY   = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // Software-visible state
    logic [15:0]   clk_cfg_reg;
    logic [15:0]   clk_cfg_next;
    logic [15:0]   stage_en_reg;
    logic [15:0]   stage_en_next;
    cfr_flags_t    mask_reg;
    cfr_flags_t    mask_next;

    // Write channel holding
    logic          aw_hold_reg;
    logic [5:0]    aw_idx_reg;
    logic          w_hold_reg;
    logic [15:0]   wdata_reg;
    logic [1:0]    wstrb_reg;
    cfr_wr_state_t wr_state_reg;
    cfr_wr_state_t wr_state_next;
    logic [1:0]    bresp_reg;

    // Read channel holding
    cfr_rd_state_t rd_state_reg;
    cfr_rd_state_t rd_state_next;
    logic [31:0]   rdata_reg;
    logic [1:0]    rresp_reg;

    cfr_irq_if     irq_bus ();

    // Merge byte lanes of a 16-bit register, writable bits only
    function automatic logic [15:0] merge16(
        input logic [15:0] old_val,
        input logic [15:0] new_val,
        input logic [1:0]  strb,
        input logic [15:0] writable
    );
        logic [15:0] lane;
        lane = {{8{strb[1]}}, {8{strb[0]}}} & writable;
        return (old_val & ~lane) | (new_val & lane);
    endfunction

    // Write path

    // Address and data are taken independently, in either order
    assign s_axi_awready = ce & ~aw_hold_reg;
    assign s_axi_wready  = ce & ~w_hold_reg;

    wire aw_take = s_axi_awvalid & s_axi_awready;
    wire w_take  = s_axi_wvalid & s_axi_wready;

    // Commit once both halves are held and no response is pending
    wire wr_commit = ce & aw_hold_reg & w_hold_reg &
                     (wr_state_reg == CFR_WR_IDLE);
    wire b_done    = ce & s_axi_bvalid & s_axi_bready;

    // Register select on the held write index
    wire wr_clk   = wr_commit &
                    (aw_idx_reg == `CFR_IDX_CLOCK_RATE_SELECT);
    wire wr_en    = wr_commit &
                    (aw_idx_reg == `CFR_IDX_STAGE_ENABLES);
    wire wr_flags = wr_commit &
                    (aw_idx_reg == `CFR_IDX_IRQ_PENDING_FLAGS);
    wire wr_mask  = wr_commit &
                    (aw_idx_reg == `CFR_IDX_IRQ_ENABLE_MASK);
    wire wr_clear = wr_commit &
                    (aw_idx_reg == `CFR_IDX_IRQ_CLEAR);
    wire wr_hit   = wr_clk | wr_en | wr_flags | wr_mask | wr_clear;

    // Holding registers for the two request halves
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            aw_hold_reg <= 1'b0;
            aw_idx_reg  <= 6'h00;
        end else if (aw_take) begin
            aw_hold_reg <= 1'b1;
            aw_idx_reg  <= s_axi_awaddr[7:2];
        end else if (wr_commit) begin
            aw_hold_reg <= 1'b0;
        end
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            w_hold_reg <= 1'b0;
            wdata_reg  <= 16'h0000;
            wstrb_reg  <= 2'h0;
        end else if (w_take) begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata[15:0];
            wstrb_reg  <= s_axi_wstrb[1:0];
        end else if (wr_commit) begin
            w_hold_reg <= 1'b0;
        end
    end

    // Response sequencer
    always_comb begin
        wr_state_next = wr_state_reg;
        case (wr_state_reg)
            CFR_WR_IDLE: begin
                if (wr_commit) begin
                    wr_state_next = CFR_WR_RESP;
                end
            end
            CFR_WR_RESP: begin
                if (b_done) begin
                    wr_state_next = CFR_WR_IDLE;
                end
            end
            default: begin
                wr_state_next = CFR_WR_IDLE;
            end
        endcase
    end

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            wr_state_reg <= CFR_WR_IDLE;
            bresp_reg    <= RESP_OKAY;
        end else if (ce) begin
            wr_state_reg <= wr_state_next;
            if (wr_commit) begin
                bresp_reg <= wr_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_bvalid = (wr_state_reg == CFR_WR_RESP);
    assign s_axi_bresp  = bresp_reg;

    // Control registers

    // Runs on the bus clock, so the reference clock may be stopped
    assign clk_cfg_next = wr_clk ?
        merge16(clk_cfg_reg, wdata_reg, wstrb_reg,
                `CFR_CLK_WRITABLE) :
        clk_cfg_reg;
    assign stage_en_next = wr_en ?
        merge16(stage_en_reg, wdata_reg, wstrb_reg,
                `CFR_EN_WRITABLE) :
        stage_en_reg;
    // Upper lane of the mask is reserved and never stored
    assign mask_next = (wr_mask & wstrb_reg[0]) ?
        wdata_reg[7:0] : mask_reg;

    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            clk_cfg_reg  <= `CFR_RST_CLOCK_RATE_SELECT;
            stage_en_reg <= `CFR_RST_STAGE_ENABLES;
            mask_reg     <= `CFR_RST_IRQ_ENABLE_MASK;
        end else if (ce) begin
            clk_cfg_reg  <= clk_cfg_next;
            stage_en_reg <= stage_en_next;
            mask_reg     <= mask_next;
        end
    end

    // Clock configuration decode

    assign ref_edge_falling = clk_cfg_reg[`CFR_CLK_EDGE_BIT];
    assign pll_bypass       = clk_cfg_reg[`CFR_CLK_BYPASS_BIT];

    // Rate fields; code zero stops that clock
    assign in_clk_rate   = cfr_rate_t'(
        clk_cfg_reg[`CFR_CLK_IN_RATE_LSB +: 2]);
    assign core_clk_rate = cfr_rate_t'(
        clk_cfg_reg[`CFR_CLK_CORE_RATE_LSB +: 2]);
    assign out_clk_rate  = cfr_rate_t'(
        clk_cfg_reg[`CFR_CLK_OUT_RATE_LSB +: 2]);
    assign clk_running   = {out_clk_rate  != CFR_RATE_OFF,
                            core_clk_rate != CFR_RATE_OFF,
                            in_clk_rate   != CFR_RATE_OFF};

    // Stored as written; only code 00 is meaningful downstream
    assign out_clk_src_sel = clk_cfg_reg[`CFR_CLK_OUT_SRC_LSB +: 2];

    // Datapath enable decode

    wire [3:0] en_nodelay = stage_en_reg[`CFR_EN_NODELAY_LSB +: 4];
    wire [3:0] en_delay   = stage_en_reg[`CFR_EN_DELAY_LSB +: 4];

    // Either group enables a stage
    assign peak_cancel_stage_en = en_nodelay | en_delay;

    // A bypassed stage drops its delay only while the without-delay
    // group alone is in use; otherwise its delay stays in the path
    assign peak_cancel_stage_skip_delay =
        ~peak_cancel_stage_en &
        {4{(|en_nodelay) & ~(|en_delay)}};

    assign interp_en  = stage_en_reg[`CFR_EN_INTERP_BIT];
    assign limiter_en = stage_en_reg[`CFR_EN_LIMITER_BIT];

    // No peak work at all, samples still pass the delay buffers
    assign datapath_bypass = (stage_en_reg == 16'h0000);

    // Interrupt flags

    // Both the flag register and the clear register clear by ones
    assign irq_bus.event_pulse = event_pulse;
    assign irq_bus.clear_pulse =
        {8{(wr_flags | wr_clear) & wstrb_reg[0]}} &
        wdata_reg[7:0];
    assign irq_bus.mask = mask_reg;

    cfr_irq_flags u_flags (
        .clk     (clk),
        .resetn  (resetn),
        .ce      (ce),
        .port_if (irq_bus)
    );

    // Host reads the flags to find the cause
    assign irq = irq_bus.irq;

    // Read path

    wire [5:0] rd_idx = s_axi_araddr[7:2];
    wire rd_clk   = (rd_idx == `CFR_IDX_CLOCK_RATE_SELECT);
    wire rd_en    = (rd_idx == `CFR_IDX_STAGE_ENABLES);
    wire rd_flags = (rd_idx == `CFR_IDX_IRQ_PENDING_FLAGS);
    wire rd_mask  = (rd_idx == `CFR_IDX_IRQ_ENABLE_MASK);
    wire rd_clear = (rd_idx == `CFR_IDX_IRQ_CLEAR);
    wire rd_hit   = rd_clk | rd_en | rd_flags | rd_mask | rd_clear;

    // Read mux; reserved bits and the clear register read zero
    wire [31:0] rd_mux =
        rd_clk   ? {16'h0000, clk_cfg_reg}                 :
        rd_en    ? {16'h0000, stage_en_reg}                :
        rd_flags ? {24'h000000, irq_bus.flags}             :
        rd_mask  ? {24'h000000, mask_reg}                  :
                   32'h00000000;

    assign s_axi_arready = ce & (rd_state_reg == CFR_RD_IDLE);

    wire ar_take = s_axi_arvalid & s_axi_arready;
    wire r_done  = ce & s_axi_rvalid & s_axi_rready;

    always_comb begin
        rd_state_next = rd_state_reg;
        case (rd_state_reg)
            CFR_RD_IDLE: begin
                if (ar_take) begin
                    rd_state_next = CFR_RD_DATA;
                end
            end
            CFR_RD_DATA: begin
                if (r_done) begin
                    rd_state_next = CFR_RD_IDLE;
                end
            end
            default: begin
                rd_state_next = CFR_RD_IDLE;
            end
        endcase
    end

    // Data is captured at the address edge, so a later flag set
    // shows on the next read, not this one
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rd_state_reg <= CFR_RD_IDLE;
            rdata_reg    <= 32'h00000000;
            rresp_reg    <= RESP_OKAY;
        end else if (ce) begin
            rd_state_reg <= rd_state_next;
            if (ar_take) begin
                rdata_reg <= rd_mux;
                rresp_reg <= rd_hit ? RESP_OKAY : RESP_SLVERR;
            end
        end
    end

    assign s_axi_rvalid = (rd_state_reg == CFR_RD_DATA);
    assign s_axi_rdata  = rdata_reg;
    assign s_axi_rresp  = rresp_reg;

endmodule

`default_nettype wire

//--- dv/cfr_ctrl_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module cfr_ctrl_monitor
    import cfr_pkg::*;
(
    // Clock, reset and bus
    input  wire logic        clk, resetn, ce,
    input  wire logic [7:0]  s_axi_awaddr, s_axi_araddr,
    input  wire logic [31:0] s_axi_wdata, s_axi_rdata,
    input  wire logic        s_axi_awvalid, s_axi_awready,
    input  wire logic        s_axi_wvalid, s_axi_wready, s_axi_bvalid,
    input  wire logic        s_axi_arvalid, s_axi_arready, s_axi_rvalid,
    // Events and decoded controls
    input  wire logic [7:0]  event_pulse,
    input  wire logic        irq, ref_edge_falling, pll_bypass,
    input  wire cfr_rate_t   in_clk_rate, core_clk_rate, out_clk_rate,
    input  wire logic [2:0]  clk_running,
    input  wire logic [1:0]  out_clk_src_sel,
    input  wire logic [3:0]  peak_cancel_stage_en,
    input  wire logic [3:0]  peak_cancel_stage_skip_delay,
    input  wire logic        interp_en, limiter_en, datapath_bypass
);
    logic [7:0]  wa_reg, ra_reg, flg_reg, msk_reg;
    logic [15:0] wd_reg;
    logic        wa_got, wd_got, bv_q;

    // Commit edge: both halves of a write held
    wire         commit  = wa_got & wd_got & ce;
    wire         clr     = commit & (wa_reg == 8'h10 || wa_reg == 8'h40);
    wire [7:0]   clr_m   = clr ? wd_reg[7:0] : 8'h00;
    wire         exp_irq = |(flg_reg & msk_reg);
    wire         wr_done = s_axi_bvalid & ~bv_q;

    // Shadow of flags and mask; set beats clear
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            {wa_reg, ra_reg, flg_reg, msk_reg} <= '0;
            {wd_reg, wa_got, wd_got, bv_q} <= '0;
        end else if (ce) begin
            if (commit) {wa_got, wd_got} <= 2'b00;
            if (s_axi_awvalid & s_axi_awready) {wa_got, wa_reg} <= {1'b1, s_axi_awaddr};
            if (s_axi_wvalid & s_axi_wready) {wd_got, wd_reg} <= {1'b1, s_axi_wdata[15:0]};
            if (commit && wa_reg == 8'h14) msk_reg <= wd_reg[7:0];
            if (s_axi_arvalid & s_axi_arready) ra_reg <= s_axi_araddr;
            flg_reg <= (flg_reg & ~clr_m) | event_pulse;
            bv_q <= s_axi_bvalid;
        end
    end
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);

    property p_clk_lo;
        wr_done && wa_reg == 8'h08 |-> ref_edge_falling == wd_reg[2]
            && pll_bypass == wd_reg[3] && in_clk_rate == wd_reg[5:4];
    endproperty
    a_clk_lo: assert property (p_clk_lo) else $error("clock low byte");
    property p_clk_hi;
        wr_done && wa_reg == 8'h08 |-> core_clk_rate == wd_reg[9:8]
            && out_clk_rate == wd_reg[13:12] && out_clk_src_sel == wd_reg[15:14];
    endproperty
    a_clk_hi: assert property (p_clk_hi) else $error("clock high byte");
    property p_clk_run;
        clk_running == {out_clk_rate != CFR_RATE_OFF,
            core_clk_rate != CFR_RATE_OFF, in_clk_rate != CFR_RATE_OFF};
    endproperty
    a_clk_run: assert property (p_clk_run) else $error("clock running");
    property p_en;
        wr_done && wa_reg == 8'h0c |->
            peak_cancel_stage_en == (wd_reg[3:0] | wd_reg[11:8])
            && peak_cancel_stage_skip_delay == (~(wd_reg[3:0] | wd_reg[11:8])
            & {4{wd_reg[3:0] != 4'h0 && wd_reg[11:8] == 4'h0}})
            && interp_en == wd_reg[4] && limiter_en == wd_reg[5];
    endproperty
    a_en: assert property (p_en) else $error("stage enables");
    property p_bypass;
        datapath_bypass |-> peak_cancel_stage_en == 4'h0 && !interp_en
            && !limiter_en && peak_cancel_stage_skip_delay == 4'h0;
    endproperty
    a_bypass: assert property (p_bypass) else $error("bypass mode");
    property p_irq_on;
        exp_irq && $past(exp_irq) |-> irq;
    endproperty
    a_irq_on: assert property (p_irq_on) else $error("irq missing");
    property p_irq_off;
        !exp_irq && !$past(exp_irq) |-> !irq;
    endproperty
    a_irq_off: assert property (p_irq_off) else $error("irq stray");
    property p_flag;
        $rose(s_axi_rvalid) && ra_reg == 8'h10 |->
            s_axi_rdata == {24'h0, $past(flg_reg)};
    endproperty
    a_flag: assert property (p_flag) else $error("flag read");
    property p_rd;
        s_axi_arvalid && s_axi_arready |=> s_axi_rvalid;
    endproperty
    a_rd: assert property (p_rd) else $error("read answer");

    c_irq:    cover property ($rose(irq));
    c_clear:  cover property (clr && (clr_m & event_pulse) != 8'h00);
    c_bypass: cover property ($fell(datapath_bypass));
endmodule

bind cfr_global_ctrl cfr_ctrl_monitor u_mon (.clk, .resetn, .ce,
    .s_axi_awaddr, .s_axi_araddr, .s_axi_wdata, .s_axi_rdata,
    .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bvalid, .s_axi_arvalid, .s_axi_arready, .s_axi_rvalid,
    .event_pulse, .irq, .ref_edge_falling, .pll_bypass, .in_clk_rate,
    .core_clk_rate, .out_clk_rate, .clk_running, .out_clk_src_sel,
    .peak_cancel_stage_en, .peak_cancel_stage_skip_delay, .interp_en,
    .limiter_en, .datapath_bypass);

`default_nettype wire

//--- dv/cfr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

module cfr_host_model (
    // Clock
    input  wire logic        clk,
    // Requests from the host
    output logic [7:0]       s_axi_awaddr, s_axi_araddr,
    output logic [2:0]       s_axi_awprot, s_axi_arprot,
    output logic [31:0]      s_axi_wdata,
    output logic [3:0]       s_axi_wstrb,
    output logic             s_axi_awvalid, s_axi_wvalid, s_axi_bready,
    output logic             s_axi_arvalid, s_axi_rready,
    // Answers from the device
    input  wire logic        s_axi_awready, s_axi_wready, s_axi_bvalid,
    input  wire logic        s_axi_arready, s_axi_rvalid, irq,
    input  wire logic [1:0]  s_axi_bresp, s_axi_rresp,
    input  wire logic [31:0] s_axi_rdata
);
    // Idle bus at time zero; both byte lanes always written
    initial begin
        {s_axi_awaddr, s_axi_araddr, s_axi_awprot, s_axi_arprot} = '0;
        {s_axi_wdata, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
        {s_axi_arvalid, s_axi_rready} = '0;
        s_axi_wstrb = 4'h3;
    end

    // Released address and data are inverted so stale values never pass
    task automatic wr(input logic [7:0] a, input logic [15:0] d,
                      output logic [1:0] r);
        logic [15:0] v;
        v = (a == 8'h08) ? {2'b00, d[13:0]} : d;
        @(posedge clk);
        s_axi_awaddr <= a;
        s_axi_wdata <= {16'h0000, v};
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= 3'b111;
        do begin
            @(posedge clk);
            if (s_axi_awvalid && s_axi_awready) begin
                s_axi_awvalid <= 1'b0;
                s_axi_awaddr <= ~s_axi_awaddr;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                s_axi_wvalid <= 1'b0;
                s_axi_wdata <= ~s_axi_wdata;
            end
        end while (s_axi_bvalid !== 1'b1);
        r = s_axi_bresp;
        s_axi_bready <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] d,
                      output logic [1:0] r);
        @(posedge clk);
        s_axi_araddr <= a;
        {s_axi_arvalid, s_axi_rready} <= 2'b11;
        do begin
            @(posedge clk);
            if (s_axi_arvalid && s_axi_arready) begin
                s_axi_arvalid <= 1'b0;
                s_axi_araddr <= ~s_axi_araddr;
            end
        end while (s_axi_rvalid !== 1'b1);
        d = s_axi_rdata;
        r = s_axi_rresp;
        s_axi_rready <= 1'b0;
    endtask

    // Interrupt service: find the causes in the flag register
    task automatic service(output logic [7:0] f);
        logic [31:0] d;
        logic [1:0]  r;
        rd(8'h10, d, r);
        f = d[7:0];
    endtask
endmodule

`default_nettype wire

//--- dv/tb.sv
`timescale 1ns/1ps
`default_nettype none

`define CHK(a, b) begin total_checks++; if ((a) !== (b)) begin n_fail++; \
    $display("[ERR] %0t got %h want %h", $time, (a), (b)); end end

module tb;
    import cfr_pkg::*;
    logic        clk = 1'b0, resetn = 1'b0, ce = 1'b1;
    logic [7:0]  event_pulse = 8'h00;
    int          n_fail = 0, total_checks = 0;
    wire [7:0]   s_axi_awaddr, s_axi_araddr;
    wire [2:0]   s_axi_awprot, s_axi_arprot, clk_running;
    wire [31:0]  s_axi_wdata, s_axi_rdata;
    wire [3:0]   s_axi_wstrb, peak_cancel_stage_en, peak_cancel_stage_skip_delay;
    wire [1:0]   s_axi_bresp, s_axi_rresp, out_clk_src_sel;
    wire         s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    wire         s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
    wire         s_axi_rvalid, s_axi_rready, irq, ref_edge_falling, pll_bypass;
    wire         interp_en, limiter_en, datapath_bypass;
    cfr_rate_t   in_clk_rate, core_clk_rate, out_clk_rate;

    always #4 clk = ~clk;

    cfr_global_ctrl DUT (.clk, .resetn, .ce, .s_axi_awaddr, .s_axi_awprot,
        .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb,
        .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
        .s_axi_bready, .s_axi_araddr, .s_axi_arprot, .s_axi_arvalid,
        .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid,
        .s_axi_rready, .event_pulse, .irq, .ref_edge_falling, .pll_bypass,
        .in_clk_rate, .core_clk_rate, .out_clk_rate, .clk_running,
        .out_clk_src_sel, .peak_cancel_stage_en,
        .peak_cancel_stage_skip_delay, .interp_en, .limiter_en,
        .datapath_bypass);
    cfr_host_model host (.clk, .s_axi_awaddr, .s_axi_araddr, .s_axi_awprot,
        .s_axi_arprot, .s_axi_wdata, .s_axi_wstrb, .s_axi_awvalid,
        .s_axi_wvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_rready,
        .s_axi_awready, .s_axi_wready, .s_axi_bvalid, .s_axi_arready,
        .s_axi_rvalid, .irq, .s_axi_bresp, .s_axi_rresp, .s_axi_rdata);

    task automatic report_and_stop();
        $display("checks %0d errors %0d", total_checks, n_fail);
        if (n_fail == 0 && total_checks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // Bus helpers; a mapped access must answer OKAY
    task automatic wchk(input logic [7:0] a, input logic [15:0] d);
        logic [1:0] r;
        host.wr(a, d, r);
        `CHK(r, 2'b00)
    endtask
    task automatic rchk(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        host.rd(a, d, r);
        `CHK(d, e)
        `CHK(r, 2'b00)
    endtask
    task automatic pulse(input logic [7:0] m);
        @(posedge clk);
        event_pulse <= m;
        @(posedge clk);
        event_pulse <= 8'h00;
    endtask

    // Watchdog, far beyond what the tests need
    initial begin
        #200000;
        n_fail++;
        report_and_stop();
    end

    initial begin
        logic [15:0] v, tbl [6];
        logic [3:0]  en;
        logic [1:0]  c, r;
        logic [7:0]  f, ex;
        logic [31:0] d;
        tbl = '{16'h000f, 16'h0005, 16'h0a00, 16'h0030, 16'hffff, 16'h0000};
        repeat (12) @(posedge clk);
        resetn <= 1'b1;
        @(posedge clk);
        // Reset values of the four stored registers
        `CHK(clk_running, 3'b111)
        `CHK(datapath_bypass, 1'b1)
        rchk(8'h08, 32'h1310);
        rchk(8'h0c, 32'h0);
        rchk(8'h10, 32'h0);
        rchk(8'h14, 32'h0);
        // Every rate code on all three clocks, edge and bypass bits
        for (int i = 0; i < 4; i++) begin
            c = 2'(i);
            v = 16'(i * 16'h1110) | 16'(i << 2);
            wchk(8'h08, v);
            rchk(8'h08, {16'h0, v});
            `CHK(in_clk_rate, c)
            `CHK(core_clk_rate, c)
            `CHK(out_clk_rate, c)
            `CHK(clk_running, {3{c != 2'b00}})
            `CHK(ref_edge_falling, c[0])
            `CHK(pll_bypass, c[1])
        end
        wchk(8'h08, 16'hffff);
        rchk(8'h08, 32'h333c);
        `CHK(out_clk_src_sel, 2'b00)
        // Stage enables with and without delay, then all zero
        foreach (tbl[k]) begin
            v = tbl[k];
            en = v[3:0] | v[11:8];
            wchk(8'h0c, v);
            rchk(8'h0c, {16'h0, v & 16'h0f3f});
            `CHK(peak_cancel_stage_en, en)
            `CHK(peak_cancel_stage_skip_delay, ~en & {4{|v[3:0] && ~|v[11:8]}})
            `CHK({limiter_en, interp_en}, v[5:4])
            `CHK(datapath_bypass, (v & 16'h0f3f) == 16'h0)
        end
        // Masked events stay pending without raising the pin
        pulse(8'hff);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b0)
        rchk(8'h10, 32'hff);
        wchk(8'h14, 16'h00a5);
        repeat (2) @(posedge clk);
        `CHK(irq, 1'b1)
        host.service(f);
        `CHK(f, 8'hff)
        // Clear one flag at a time through both clear registers
        ex = 8'hff;
        for (int i = 0; i < 8; i++) begin
            wchk(i[0] ? 8'h40 : 8'h10, 16'h0100 | 16'(1 << i));
            ex[i] = 1'b0;
            rchk(8'h10, {24'h0, ex});
            repeat (2) @(posedge clk);
            `CHK(irq, |(ex & 8'ha5))
        end
        // Event on the clearing edge keeps its flag
        pulse(8'h04);
        fork
            wchk(8'h10, 16'h0004);
            begin
                @(posedge clk iff (s_axi_awvalid && s_axi_awready));
                event_pulse <= 8'h04;
                @(posedge clk);
                event_pulse <= 8'h00;
            end
        join
        rchk(8'h10, 32'h04);
        rchk(8'h40, 32'h0);
        // Unmapped place refuses and reads zero
        host.wr(8'h20, 16'hffff, r);
        `CHK(r, 2'b10)
        host.rd(8'h20, d, r);
        `CHK({r, d}, {2'b10, 32'h0})
        report_and_stop();
    end
endmodule

`default_nettype wire
